// *** design/ssfc_top.sv ***
// ssfc_top: pin control of a synchronous flow-through burst sram
`timescale 1ns/100ps
`default_nettype none
module ssfc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // synchronous control from the controller
  input wire logic clockQualifierN,
  input wire logic chipSelectAN,
  input wire logic chipSelectB,
  input wire logic chipSelectCN,
  input wire logic writeEnableN,
  input wire logic advanceLoadN,
  input wire logic [ssfc_pkg::LANES-1:0] byteLaneWriteN,
  input wire logic [ssfc_pkg::ADDR_W-1:0] address,
  // asynchronous pins
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  input wire logic burstModeStrap,
  // data pins
  input wire logic [ssfc_pkg::LANES*ssfc_pkg::BYTE_W-1:0] dataIn,
  output logic [ssfc_pkg::LANES*ssfc_pkg::BYTE_W-1:0] dataOut,
  output logic dataOe,
  // parity pins
  input wire logic [ssfc_pkg::LANES-1:0] parityIoIn,
  output logic [ssfc_pkg::LANES-1:0] parityIoOut,
  output logic parityIoOe
);
  import ssfc_pkg::*;

  ssfc_top_s state_q;
  ssfc_top_s state_d;
  ssfc_core_if core ();

  logic enabled;
  logic selected;
  logic loadEdge;
  logic deselEdge;
  logic advEdge;
  logic opIsWrite;
  logic [ADDR_W-1:0] effAddr;
  logic [WORD_W-1:0] pinWord;
  logic [WORD_W-1:0] fwdWord;

  // burst address counter
  ssfc_burst_ctr u_burst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(core.burst)
  );

  // storage array
  ssfc_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(core.mem)
  );

  // edge qualification and select decode
  assign enabled = !clockQualifierN && !state_q.sleepSync2;
  assign selected = !chipSelectAN && chipSelectB && !chipSelectCN;
  assign loadEdge = enabled && !advanceLoadN && selected;
  assign deselEdge = enabled && !advanceLoadN && !selected;
  assign advEdge = enabled && advanceLoadN && state_q.active;

  // burst counter hookup; strap is static, read through its synchroniser
  assign core.load = loadEdge;
  assign core.advance = advEdge;
  assign core.startLow = address[BEAT_W-1:0];
  assign core.interleave = state_q.modeSync2;

  // address of this beat and the kind of access
  assign effAddr = loadEdge ? address
    : {state_q.baseAddr[ADDR_W-1:BEAT_W], core.lowOut};
  assign opIsWrite = loadEdge ? !writeEnableN : state_q.isWrite;

  // pins folded into lanes of byte plus parity
  always_comb
  begin
    pinWord = '0;
    for (int i = 0; i < LANES; i++)
    begin
      pinWord[i*LANE_W +: LANE_W] = {parityIoIn[i],
        dataIn[i*BYTE_W +: BYTE_W]};
    end
  end

  // write of the pending beat, data taken from the pins this edge
  assign core.wrEn = enabled && state_q.pendWrite;
  assign core.wrAddr = state_q.pendAddr;
  assign core.wrLanes = state_q.pendLanes;
  assign core.wrWord = pinWord;
  assign core.rdAddr = effAddr;

  // read word, forwarding lanes being written on the same edge
  always_comb
  begin
    fwdWord = core.rdWord;
    for (int i = 0; i < LANES; i++)
    begin
      if (core.wrEn && core.wrLanes[i] && core.wrAddr == effAddr)
        fwdWord[i*LANE_W +: LANE_W] = pinWord[i*LANE_W +: LANE_W];
    end
  end

  // next control state
  always_comb
  begin
    state_d = state_q;
    state_d.oeSync1 = outputEnableN;
    state_d.oeSync2 = state_q.oeSync1;
    state_d.sleepSync1 = sleepRequest;
    state_d.sleepSync2 = state_q.sleepSync1;
    state_d.modeSync1 = burstModeStrap;
    state_d.modeSync2 = state_q.modeSync1;
    if (enabled)
    begin
      // previous beat ends only on a recognised edge or in sleep
      state_d.pendWrite = 1'b0;
      state_d.rdValid = 1'b0;
      if (!dataOe)
        state_d.wrData = pinWord;
      if (loadEdge)
      begin
        state_d.active = 1'b1;
        state_d.isWrite = !writeEnableN;
        state_d.baseAddr = address;
      end
      if (deselEdge)
        state_d.active = 1'b0;
      if (loadEdge || advEdge)
      begin
        if (opIsWrite)
        begin
          state_d.pendWrite = 1'b1;
          state_d.pendAddr = effAddr;
          state_d.pendLanes = ~byteLaneWriteN;
        end
        else
        begin
          state_d.rdValid = 1'b1;
          state_d.rdData = fwdWord;
        end
      end
    end
    else if (state_q.sleepSync2)
    begin
      // sleep drops any access; the array keeps its contents
      state_d.active = 1'b0;
      state_d.pendWrite = 1'b0;
      state_d.rdValid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // pin direction: only read data, enabled, awake
  assign dataOe = state_q.rdValid && !state_q.oeSync2
    && !state_q.sleepSync2;
  assign parityIoOe = dataOe;

  // output data lanes from the read register
  always_comb
  begin
    dataOut = '0;
    parityIoOut = '0;
    for (int i = 0; i < LANES; i++)
    begin
      dataOut[i*BYTE_W +: BYTE_W] = state_q.rdData[i*LANE_W +: BYTE_W];
      parityIoOut[i] = state_q.rdData[i*LANE_W + BYTE_W];
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // qualifier high freezes the access state unless asleep
  stateHold_a: assert property (
    clockQualifierN && !state_q.sleepSync2
    |=> $stable(state_q.rdValid) && $stable(state_q.active)
      && $stable(state_q.pendWrite) && $stable(state_q.rdData))
    else $error("state moved while clock qualifier high");

  // selected read load on a recognised edge starts a read beat
  readStart_a: assert property (
    enabled && !advanceLoadN && selected && writeEnableN
    |=> state_q.rdValid && state_q.rdData == $past(fwdWord))
    else $error("read not started on enabled load edge");

  // deselect load kills the access
  deselect_a: assert property (
    enabled && !advanceLoadN && !selected
    |=> !state_q.active && !dataOe && !parityIoOe)
    else $error("device stayed selected");

  // output enable held high turns pins round to inputs
  oeOff_a: assert property (
    outputEnableN [*2] |=> !dataOe)
    else $error("data driven with output enable high");

  // no drive while a write beat waits for its data
  writePhase_a: assert property (
    state_q.pendWrite |-> !dataOe && !parityIoOe)
    else $error("data driven in write data phase");

  // sleep quiets pins and stops writes
  sleepQuiet_a: assert property (
    sleepRequest [*3] |=> !dataOe && !core.wrEn)
    else $error("activity during sleep");

  // input data lands in the write data register
  wrCapture_a: assert property (
    enabled && !dataOe |=> state_q.wrData == $past(pinWord))
    else $error("write data register missed pins");

  // write beat is followed by a lane write at the next recognised edge
  writeBeat_a: assert property (
    enabled && !advanceLoadN && selected && !writeEnableN
    ##1 enabled [*1]
    |-> core.wrEn && core.wrLanes == ~$past(byteLaneWriteN))
    else $error("write beat lanes not applied");

  // deselected device never drives the pins
  deselIdle_a: assert property (
    !state_q.active |-> !dataOe && !parityIoOe)
    else $error("pins driven while deselected");

  // advance with no open access starts nothing
  advIgnore_a: assert property (
    enabled && advanceLoadN && !state_q.active
    |=> !state_q.rdValid && !state_q.pendWrite)
    else $error("advance acted while deselected");

  // advance inside a read burst gives the next read beat
  advRead_a: assert property (
    advEdge && !state_q.isWrite |=> state_q.rdValid)
    else $error("read burst beat missing");

  // write load opens a write data phase, not a read
  wrLoad_a: assert property (
    loadEdge && !writeEnableN |=> state_q.pendWrite && !state_q.rdValid)
    else $error("write load did not start a write beat");

  // load edge uses the pin address and seeds the counter
  loadAddr_a: assert property (
    loadEdge |-> core.rdAddr == address
      && core.lowOut == address[BEAT_W-1:0])
    else $error("load address not taken");

  // burst beats stay inside the four-word block
  burstBlock_a: assert property (
    advEdge |-> core.rdAddr[ADDR_W-1:BEAT_W]
      == state_q.baseAddr[ADDR_W-1:BEAT_W])
    else $error("burst left its block");

  // asleep: no array write and no drive
  sleepWrite_a: assert property (
    state_q.sleepSync2 |-> !core.wrEn && !dataOe)
    else $error("array touched during sleep");

  // ignored edge never writes the array
  qualWrite_a: assert property (
    clockQualifierN |-> !core.wrEn)
    else $error("write on an ignored edge");

  // output enable held low lets read data out
  oeDrive_a: assert property (
    !outputEnableN [*2] ##1 (state_q.rdValid && !state_q.sleepSync2)
    |-> dataOe)
    else $error("read data not driven with output enable low");

  // strap high settles to interleaved order
  modeHigh_a: assert property (
    burstModeStrap [*3] |-> core.interleave)
    else $error("strap high did not pick interleaved order");

  // strap low settles to linear order
  modeLow_a: assert property (
    !burstModeStrap [*3] |-> !core.interleave)
    else $error("strap low did not pick linear order");
endmodule
`default_nettype wire

// *** design/ssfc_pkg.sv ***
// ssfc_pkg: widths, layouts and state types of the flow-through sram pins
package ssfc_pkg;
  // address and data layout of the 36-bit part
  localparam int ADDR_W = 21;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  // burst counter covers the two low address bits
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  // clock figures
  localparam int CLK_PERIOD_NS = 25;

  // burst counter state
  typedef struct packed {
    logic [BEAT_W-1:0] start;
    logic [BEAT_W-1:0] beat;
  } ssfc_burst_s;

  // pin-control state of the top
  typedef struct packed {
    logic oeSync1;
    logic oeSync2;
    logic sleepSync1;
    logic sleepSync2;
    logic modeSync1;
    logic modeSync2;
    logic active;
    logic isWrite;
    logic pendWrite;
    logic [ADDR_W-1:0] pendAddr;
    logic [LANES-1:0] pendLanes;
    logic [ADDR_W-1:0] baseAddr;
    logic rdValid;
    logic [WORD_W-1:0] rdData;
    logic [WORD_W-1:0] wrData;
  } ssfc_top_s;
endpackage

// *** design/ssfc_core_if.sv ***
// ssfc_core_if: burst counter and memory array links inside the sram
`timescale 1ns/100ps
`default_nettype none
interface ssfc_core_if;
  import ssfc_pkg::*;
  // burst counter group
  logic load;
  logic advance;
  logic [BEAT_W-1:0] startLow;
  logic interleave;
  logic [BEAT_W-1:0] lowOut;
  // memory group
  logic [ADDR_W-1:0] rdAddr;
  logic [WORD_W-1:0] rdWord;
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [LANES-1:0] wrLanes;
  logic [WORD_W-1:0] wrWord;

  modport ctl (
    output load, advance, startLow, interleave, rdAddr, wrEn, wrAddr,
    output wrLanes, wrWord,
    input lowOut, rdWord
  );
  modport burst (
    input load, advance, startLow, interleave,
    output lowOut
  );
  modport mem (
    input rdAddr, wrEn, wrAddr, wrLanes, wrWord,
    output rdWord
  );
endinterface
`default_nettype wire

// *** design/ssfc_burst_ctr.sv ***
// ssfc_burst_ctr: two-bit burst counter, linear or interleaved order
`timescale 1ns/100ps
`default_nettype none
module ssfc_burst_ctr (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to the pin control
  ssfc_core_if.burst bus
);
  import ssfc_pkg::*;

  ssfc_burst_s state_q;
  ssfc_burst_s state_d;
  logic [BEAT_W-1:0] nextBeat;

  // next beat and the low address bits for this edge
  always_comb
  begin
    state_d = state_q;
    nextBeat = state_q.beat + BEAT_ONE;
    if (bus.load)
    begin
      bus.lowOut = bus.startLow;
      state_d.start = bus.startLow;
      state_d.beat = '0;
    end
    else if (bus.interleave)
    begin
      bus.lowOut = state_q.start ^ nextBeat;
    end
    else
    begin
      bus.lowOut = state_q.start + nextBeat;
    end
    if (bus.advance && !bus.load)
    begin
      state_d.beat = nextBeat;
    end
  end

  // counter register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // four advances return to the start address
  burstWrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus.load ##1 (bus.advance && !bus.load) [*4]
    |-> bus.lowOut == $past(bus.lowOut, 4))
    else $error("burst did not wrap after four beats");

  // interleaved second beat flips bit zero
  interOrder_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus.load ##1 (bus.advance && !bus.load && bus.interleave)
    |-> bus.lowOut == ($past(bus.lowOut) ^ BEAT_ONE))
    else $error("interleaved order wrong on second beat");
endmodule
`default_nettype wire

// *** design/ssfc_mem.sv ***
// ssfc_mem: storage array with per-lane writes and parity per lane
`timescale 1ns/100ps
`default_nettype none
module ssfc_mem (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to the pin control
  ssfc_core_if.mem bus
);
  import ssfc_pkg::*;

  logic [WORD_W-1:0] store [DEPTH];

  // asynchronous read port
  assign bus.rdWord = store[bus.rdAddr];

  // lane-gated write, parity bit follows its byte
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (bus.wrEn && bus.wrLanes[i])
        store[bus.wrAddr][i*LANE_W +: LANE_W] <=
          bus.wrWord[i*LANE_W +: LANE_W];
    end
  end

  // written lane zero holds the data and parity given
  laneWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus.wrEn && bus.wrLanes[0]
    |=> store[$past(bus.wrAddr)][LANE_W-1:0] == $past(bus.wrWord[LANE_W-1:0]))
    else $error("lane zero write lost");
endmodule
`default_nettype wire

// *** bench/ssfc_ctl_model.sv ***
// ssfc_ctl_model: controller side of the shared data and parity wires
`timescale 1ns/100ps
`default_nettype none
module ssfc_ctl_model (
  // clock
  input wire logic clk_sys,
  // sram side
  input wire logic [35:0] devWord,
  input wire logic devOe,
  // controller side
  input wire logic [35:0] hostWord,
  input wire logic hostDrive,
  output logic [35:0] pinWord
);
  logic [35:0] lastQ = 36'h0;
  // wire owner; a released wire shows the inverse of its last level
  always_comb
  begin
    if (devOe)
      pinWord = devWord;
    else if (hostDrive)
      pinWord = hostWord;
    else
      pinWord = ~lastQ;
  end
  // last driven level
  always_ff @(posedge clk_sys)
  begin
    if (devOe || hostDrive)
      lastQ <= pinWord;
  end
endmodule
`default_nettype wire

// *** bench/sync_flow_sram_control_pins_bench.sv ***
// sync_flow_sram_control_pins_bench: self-checking bench of ssfc_top
`timescale 1ns/100ps
`default_nettype none
module sync_flow_sram_control_pins_bench;
  import ssfc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clockQualifierN = 1'b0;
  logic chipSelectAN = 1'b0;
  logic chipSelectB = 1'b1;
  logic chipSelectCN = 1'b0;
  logic writeEnableN = 1'b1;
  logic advanceLoadN = 1'b1;
  logic [LANES-1:0] byteLaneWriteN = 4'hf;
  logic [ADDR_W-1:0] address = 21'h0;
  logic outputEnableN = 1'b0;
  logic sleepRequest = 1'b0;
  logic burstModeStrap = 1'b0;
  logic [35:0] hostWord = 36'h0;
  logic hostDrive = 1'b0;
  logic [35:0] pinWord;
  logic [31:0] dataOut;
  logic [3:0] parityIoOut;
  logic dataOe, parityIoOe;
  // pin drive enables widened for compare
  logic [35:0] oePair;
  assign oePair = {34'h0, parityIoOe, dataOe};
  int fail_count = 0;
  int check_count = 0;

  // device under test
  ssfc_top dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clockQualifierN(clockQualifierN),
    .chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB),
    .chipSelectCN(chipSelectCN), .writeEnableN(writeEnableN),
    .advanceLoadN(advanceLoadN), .byteLaneWriteN(byteLaneWriteN),
    .address(address), .outputEnableN(outputEnableN),
    .sleepRequest(sleepRequest), .burstModeStrap(burstModeStrap),
    .dataIn(pinWord[31:0]), .dataOut(dataOut), .dataOe(dataOe),
    .parityIoIn(pinWord[35:32]), .parityIoOut(parityIoOut),
    .parityIoOe(parityIoOe)
  );
  // controller wire model
  ssfc_ctl_model model_u (
    .clk_sys(clk_sys), .devWord({parityIoOut, dataOut}), .devOe(dataOe),
    .hostWord(hostWord), .hostDrive(hostDrive), .pinWord(pinWord)
  );

  // clock
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [35:0] e, input logic [35:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected at %0t: want %h got %h", $time, e, g);
      fail_count++;
    end
  endtask

  // one enabled edge: ld loads a, w low writes, dv drives data wires
  task automatic drv(input logic ld, input logic w, input logic [3:0] bl,
    input logic [20:0] a, input logic dv, input logic [35:0] d);
    @(negedge clk_sys);
    advanceLoadN = ~ld;
    writeEnableN = w;
    byteLaneWriteN = bl;
    address = a;
    hostDrive = dv;
    hostWord = d;
    @(posedge clk_sys);
    #1;
  endtask

  // full write, forwarded read, then a single-lane write
  task automatic t_rw;
    drv(1'b1, 1'b0, 4'h0, 21'h100, 1'b0, 36'h0);
    chk(36'h0, oePair);
    drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b1, 36'h9_1234_5678);
    chk(36'h9_1234_5678, {parityIoOut, dataOut});
    chk(36'h3, oePair);
    drv(1'b1, 1'b0, 4'he, 21'h100, 1'b0, 36'h0);
    drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b1, 36'h6_abcd_ef01);
    chk(36'h8_1234_5601, {parityIoOut, dataOut});
  endtask

  // four writes then a burst read from low bits s
  task automatic t_burst(input logic m, input logic [1:0] s);
    logic [1:0] lo;
    @(negedge clk_sys);
    burstModeStrap = m;
    for (int i = 0; i < 4; i++)
      drv(1'b1, 1'b0, 4'h0, 21'h200 + 21'(i), i > 0, 36'(i + 3));
    drv(1'b1, 1'b1, 4'hf, 21'h200 + 21'(s), 1'b1, 36'h7);
    chk(36'(s) + 36'h4, {parityIoOut, dataOut});
    for (int k = 1; k < 5; k++)
    begin
      drv(1'b0, 1'b1, 4'hf, 21'h0, 1'b0, 36'h0);
      lo = m ? (s ^ 2'(k)) : (s + 2'(k));
      chk(36'(lo) + 36'h4, {parityIoOut, dataOut});
    end
  endtask

  // stretched cycle, select decode, output enable, sleep
  task automatic t_ctl;
    drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b0, 36'h0);
    @(negedge clk_sys);
    clockQualifierN = 1'b1;
    address = 21'h200;
    advanceLoadN = 1'b0;
    chipSelectB = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(36'h8_1234_5601, {parityIoOut, dataOut});
    chk(36'h3, oePair);
    @(negedge clk_sys);
    clockQualifierN = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(36'h0, oePair);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys);
      {chipSelectAN, chipSelectB, chipSelectCN} = 3'(i);
      drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b0, 36'h0);
      chk((i == 2) ? 36'h3 : 36'h0, oePair);
    end
    @(negedge clk_sys);
    {chipSelectAN, chipSelectB, chipSelectCN} = 3'h2;
    outputEnableN = 1'b1;
    repeat (3) drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b0, 36'h0);
    chk(36'h0, oePair);
    @(negedge clk_sys);
    outputEnableN = 1'b0;
    sleepRequest = 1'b1;
    repeat (4) drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b0, 36'h0);
    chk(36'h0, oePair);
    @(negedge clk_sys);
    sleepRequest = 1'b0;
    repeat (4) drv(1'b1, 1'b1, 4'hf, 21'h100, 1'b0, 36'h0);
    chk(36'h8_1234_5601, {parityIoOut, dataOut});
    chk(36'h3, oePair);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    t_rw;
    t_burst(1'b0, 2'h1);
    t_burst(1'b1, 2'h1);
    t_ctl;
    conclude;
  end

  // watchdog
  initial
  begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
